// [hdl/mcsd_top.sv]
// Probe channel select decoder with its register bus slave and probe routing outputs.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps

// Operation
// - Monitor select: select bits zero, function 1010.
// - Wide variant takes code from bits 13..8.
// - Narrow variant takes code from bits 11..6.
// - Codes below channel count route that channel.
// - Codes 100100 and 100101 route external inputs.
// - Code 63 puts the probe pin high-Z.
// - Function 1100 loads bits 13..0 into control.
// - Probe enable clear keeps the pin high-Z.
// - Special functions need both select bits zero.
module mcsd_top #(
    parameter int unsigned DATA_BITS = 14,
    parameter int unsigned CHANNELS  = 16
) (
    input  wire logic                         core_clk,
    input  wire logic                         sys_rst,
    input  wire logic                         ce,
    input  wire logic [mcsd_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [mcsd_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    output logic [3:0]                        probe_chan_sel,
    output logic                              probe_chan_en,
    output logic                              probe_ext_a_en,
    output logic                              probe_ext_b_en,
    output logic                              probe_output_oe
);
    import mcsd_pkg::*;

    // ==========================================================
    // Declarations
    mcsd_wr_state_t              wr_state_q;
    logic                        aw_got_q;
    logic                        w_got_q;
    logic [ADDR_W-1:0]           awaddr_q;
    logic [31:0]                 wdata_q;
    logic [1:0]                  bresp_q;
    logic                        rvalid_q;
    logic [31:0]                 rdata_q;
    logic [1:0]                  rresp_q;
    logic [CMD_W-1:0]            cmd_q;
    logic [CMD_DATA_W-1:0]       ctrl_q;
    logic [SRC_W-1:0]            code_q;
    logic [3:0]                  chan_sel_q;
    logic                        chan_en_q;
    logic                        ext_a_q;
    logic                        ext_b_q;
    logic                        oe_q;
    logic                        wr_fire;
    logic                        wr_is_cmd;
    logic                        cmd_fire;
    logic [CMD_W-1:0]            cmd_word;
    logic                        is_mon_select;
    logic                        is_ctrl_write;
    logic [SRC_W-1:0]            src_code;
    logic [CMD_DATA_W-1:0]       ctrl_data;
    logic                        probe_enable_bit;
    mcsd_route_t                 route;
    logic [31:0]                 rd_word;
    logic                        rd_hit;

    // ==========================================================
    // Write channels
    // Ready drops with ce so no handshake is taken while state is frozen.
    assign s_axi_awready = ce && !aw_got_q && (wr_state_q == WR_IDLE);
    assign s_axi_wready  = ce && !w_got_q && (wr_state_q == WR_IDLE);
    assign s_axi_bvalid  = (wr_state_q == WR_RESP);
    assign s_axi_bresp   = bresp_q;

    assign wr_fire   = ce && aw_got_q && w_got_q && (wr_state_q == WR_IDLE);
    assign wr_is_cmd = awaddr_q[ADDR_W-1:2] == OFS_CMD[ADDR_W-1:2];
    assign cmd_fire  = wr_fire && wr_is_cmd;
    assign cmd_word  = wdata_q[CMD_W-1:0];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_got_q <= 1'h0;
            awaddr_q <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'h1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_q <= 1'h0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            w_got_q <= 1'h0;
            wdata_q <= '0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'h1;
                wdata_q <= mcsd_strb_f(s_axi_wdata, s_axi_wstrb);
            end else if (wr_fire) begin
                w_got_q <= 1'h0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_state_q <= WR_IDLE;
            bresp_q    <= RESP_OKAY;
        end else if (ce) begin
            unique case (wr_state_q)
                WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state_q <= WR_RESP;
                        bresp_q    <= wr_is_cmd ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_q <= WR_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Command decode and state
    mcsd_cmd_decode #(
        .DATA_BITS (DATA_BITS)
    ) u_decode (
        .cmd_word      (cmd_word),
        .is_mon_select (is_mon_select),
        .is_ctrl_write (is_ctrl_write),
        .src_code      (src_code),
        .ctrl_data     (ctrl_data)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cmd_q <= '0;
        end else if (ce && cmd_fire) begin
            cmd_q <= cmd_word;
        end
    end

    // Words with a nonzero select bit address channel data and are ignored here.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (ce && cmd_fire && is_ctrl_write) begin
            ctrl_q <= ctrl_data;
        end
    end

    // A source chosen while probing is off is kept and takes effect once enabled.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            code_q <= SRC_HIZ;
        end else if (ce && cmd_fire && is_mon_select) begin
            code_q <= src_code;
        end
    end

    // ==========================================================
    // Probe routing
    assign probe_enable_bit = ctrl_q[CTRL_PROBE_EN_POS];
    assign route            = mcsd_route_f(code_q, CHANNELS);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            chan_sel_q <= 4'h0;
            chan_en_q  <= 1'h0;
            ext_a_q    <= 1'h0;
            ext_b_q    <= 1'h0;
            oe_q       <= 1'h0;
        end else if (ce) begin
            chan_sel_q <= code_q[3:0];
            chan_en_q  <= probe_enable_bit && (route == ROUTE_CHAN);
            ext_a_q    <= probe_enable_bit && (route == ROUTE_EXT_A);
            ext_b_q    <= probe_enable_bit && (route == ROUTE_EXT_B);
            oe_q       <= probe_enable_bit && (route != ROUTE_HIZ);
        end
    end

    assign probe_chan_sel  = chan_sel_q;
    assign probe_chan_en   = chan_en_q;
    assign probe_ext_a_en  = ext_a_q;
    assign probe_ext_b_en  = ext_b_q;
    assign probe_output_oe = oe_q;

    // ==========================================================
    // Read channel
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'h1;
        if (s_axi_araddr[ADDR_W-1:2] == OFS_CMD[ADDR_W-1:2]) begin
            rd_word[CMD_W-1:0] = cmd_q;
        end else if (s_axi_araddr[ADDR_W-1:2] == OFS_CTRL[ADDR_W-1:2]) begin
            rd_word[CMD_DATA_W-1:0] = ctrl_q;
        end else if (s_axi_araddr[ADDR_W-1:2] == OFS_STAT[ADDR_W-1:2]) begin
            rd_word[SRC_W-1:0]                = code_q;
            rd_word[STAT_ROUTE_LSB +: 2]      = route;
            rd_word[STAT_OE_POS]              = oe_q;
            rd_word[STAT_EN_POS]              = probe_enable_bit;
        end else begin
            rd_hit = 1'h0;
        end
    end

    assign s_axi_arready = ce && !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rvalid_q <= 1'h0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'h1;
                rdata_q  <= rd_word;
                rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'h0;
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_monsel_load: assert property (
        cmd_fire && cmd_word[19:14] == 6'h0A |=> code_q == $past(src_code)
    ) else $error("monitor select did not load the source code");

    a_sfr_gate: assert property (
        cmd_fire && (cmd_word[19] || cmd_word[18]) |=> $stable(code_q) && $stable(ctrl_q)
    ) else $error("non special function word changed state");

    a_wide_field: assert property (
        DATA_BITS == 14 && cmd_fire && is_mon_select |=> code_q == $past(wdata_q[13:8])
    ) else $error("wide variant took the wrong code field");

    a_narrow_field: assert property (
        DATA_BITS == 12 && cmd_fire && is_mon_select |=> code_q == $past(wdata_q[11:6])
    ) else $error("narrow variant took the wrong code field");

    a_chan_route: assert property (
        ce && probe_enable_bit && 32'(code_q) < CHANNELS
            |=> probe_chan_en && probe_output_oe && probe_chan_sel == $past(code_q[3:0])
    ) else $error("channel code not routed to its channel");

    a_ext_route: assert property (
        ce && probe_enable_bit && (code_q == 6'h24 || code_q == 6'h25)
            |=> probe_output_oe && (probe_ext_a_en != probe_ext_b_en)
                && probe_ext_b_en == $past(code_q[0])
    ) else $error("external input code not routed");

    a_hiz_code: assert property (
        ce && code_q == 6'h3F |=> !probe_output_oe && !probe_chan_en
    ) else $error("code 63 did not three-state the probe pin");

    a_ctrl_load: assert property (
        cmd_fire && cmd_word[19:14] == 6'h0C |=> ctrl_q == $past(wdata_q[13:0])
    ) else $error("control write did not load the control register");

    a_disable_hiz: assert property (
        ce && !ctrl_q[9] |=> !probe_output_oe && !probe_chan_en && !probe_ext_a_en && !probe_ext_b_en
    ) else $error("probe pin driven while probing is disabled");

    a_unassigned_hiz: assert property (
        ce && 32'(code_q) >= CHANNELS && code_q != 6'h24 && code_q != 6'h25
            |=> !probe_output_oe
    ) else $error("unassigned code drove the probe pin");

    c_chan_probe: cover property (cmd_fire && is_mon_select ##2 probe_chan_en);
    c_ext_b_probe: cover property (probe_ext_b_en);
    c_enable_write: cover property (cmd_fire && is_ctrl_write ##1 probe_enable_bit);
    c_bad_write: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);

endmodule // mcsd_top

// [hdl/mcsd_pkg.sv]
// Package with offsets, fields, codes and types of the probe channel select decoder.
package mcsd_pkg;

    // ==========================================================
    // Register bus map
    localparam int unsigned  ADDR_W      = 8;
    localparam logic [7:0]   OFS_CMD     = 8'h00;
    localparam logic [7:0]   OFS_CTRL    = 8'h04;
    localparam logic [7:0]   OFS_STAT    = 8'h08;
    localparam logic [1:0]   RESP_OKAY   = 2'h0;
    localparam logic [1:0]   RESP_SLVERR = 2'h2;

    // ==========================================================
    // Command word layout
    localparam int unsigned  CMD_W          = 20;
    localparam int unsigned  CMD_SEL_HI_POS = 19;
    localparam int unsigned  CMD_SEL_LO_POS = 18;
    localparam int unsigned  CMD_FA_LSB     = 14;
    localparam int unsigned  CMD_FA_W       = 4;
    localparam int unsigned  CMD_DATA_W     = 14;
    localparam logic [3:0]   FA_MON_SELECT  = 4'hA;
    localparam logic [3:0]   FA_CTRL_WRITE  = 4'hC;

    // ==========================================================
    // Probe source codes
    localparam int unsigned  SRC_W          = 6;
    localparam int unsigned  SRC_WIDE_LSB   = 8;
    localparam int unsigned  SRC_NARROW_LSB = 6;
    localparam logic [5:0]   SRC_EXT_A      = 6'h24;
    localparam logic [5:0]   SRC_EXT_B      = 6'h25;
    localparam logic [5:0]   SRC_HIZ        = 6'h3F;

    // ==========================================================
    // Control register and status layout
    localparam logic [13:0]  CTRL_RESET        = 14'h2000;
    localparam int unsigned  CTRL_PROBE_EN_POS = 9;
    localparam int unsigned  STAT_ROUTE_LSB    = 8;
    localparam int unsigned  STAT_OE_POS       = 10;
    localparam int unsigned  STAT_EN_POS       = 11;

    typedef enum logic [1:0] {
        ROUTE_HIZ   = 2'h0,
        ROUTE_CHAN  = 2'h1,
        ROUTE_EXT_A = 2'h3,
        ROUTE_EXT_B = 2'h2
    } mcsd_route_t;

    typedef enum logic {
        WR_IDLE = 1'h0,
        WR_RESP = 1'h1
    } mcsd_wr_state_t;

    // Unassigned codes fall to high impedance so the pin never shows a stray node.
    function automatic mcsd_route_t mcsd_route_f(input logic [5:0] code, input int unsigned chans);
        mcsd_route_t r;
        r = ROUTE_HIZ;
        if (32'(code) < chans) begin
            r = ROUTE_CHAN;
        end else if (code == SRC_EXT_A) begin
            r = ROUTE_EXT_A;
        end else if (code == SRC_EXT_B) begin
            r = ROUTE_EXT_B;
        end
        return r;
    endfunction

    // Byte lanes without a strobe are taken as zero.
    function automatic logic [31:0] mcsd_strb_f(input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[8*i +: 8] = s[i] ? d[8*i +: 8] : 8'h00;
        end
        return m;
    endfunction

endpackage

// [hdl/mcsd_cmd_decode.sv]
// Command word decoder: special function recognition and probe source field extraction.
`timescale 1ns/1ps
module mcsd_cmd_decode #(
    parameter int unsigned DATA_BITS = 14
) (
    input  wire logic [mcsd_pkg::CMD_W-1:0]      cmd_word,
    output logic                                 is_mon_select,
    output logic                                 is_ctrl_write,
    output logic [mcsd_pkg::SRC_W-1:0]           src_code,
    output logic [mcsd_pkg::CMD_DATA_W-1:0]      ctrl_data
);
    import mcsd_pkg::*;

    logic                register_select_hi;
    logic                register_select_lo;
    logic                special_function_command;
    logic [CMD_FA_W-1:0] function_addr;

    assign register_select_hi       = cmd_word[CMD_SEL_HI_POS];
    assign register_select_lo       = cmd_word[CMD_SEL_LO_POS];
    assign special_function_command = !register_select_hi && !register_select_lo;
    assign function_addr            = cmd_word[CMD_FA_LSB +: CMD_FA_W];

    assign is_mon_select = special_function_command && (function_addr == FA_MON_SELECT);
    assign is_ctrl_write = special_function_command && (function_addr == FA_CTRL_WRITE);

    // The narrow variant keeps its code two bits lower in the payload.
    generate
        if (DATA_BITS == 12) begin : g_narrow
            assign src_code = cmd_word[SRC_NARROW_LSB +: SRC_W];
        end else begin : g_wide
            assign src_code = cmd_word[SRC_WIDE_LSB +: SRC_W];
        end
    endgenerate

    assign ctrl_data = cmd_word[CMD_DATA_W-1:0];

endmodule // mcsd_cmd_decode

// [verif/mcsd_host_model.sv]
// Register bus master model standing in for the host that issues command words.
`timescale 1ns/1ps
module mcsd_host_model (
    input  wire logic        core_clk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
    end

    // ==========================================================
    // Bus cycles
    // Released payload is inverted so a slave that samples it late sees garbage, not the old value.
    // Waits carry no limit of their own; a hung slave is ended by the bench watchdog.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r);
        r = 2'bxx;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= st;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~d;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        d = 'x;
        r = 2'bxx;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~a;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule // mcsd_host_model

// [verif/tb_top.sv]
// Self-checking testbench for the probe channel select decoder, wide and narrow variants.
`timescale 1ns/1ps
module tb_top;
    import mcsd_pkg::*;
    logic        core_clk, sys_rst, ce;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, probe_chan_sel, n_chan_sel;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        probe_chan_en, probe_ext_a_en, probe_ext_b_en, probe_output_oe;
    logic        n_chan_en, n_ext_a_en, n_ext_b_en, n_output_oe;
    logic [13:0] ctrl_m;
    logic [5:0]  code_w, code_n;
    logic [13:0] pay;
    int          num_errors, n_checks;

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ==========================================================
    // Instances
    mcsd_host_model mcsd_host_model_inst (.core_clk(core_clk), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    mcsd_top #(.DATA_BITS(14), .CHANNELS(16)) mcsd_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .probe_chan_sel(probe_chan_sel),
        .probe_chan_en(probe_chan_en), .probe_ext_a_en(probe_ext_a_en), .probe_ext_b_en(probe_ext_b_en),
        .probe_output_oe(probe_output_oe));
    // The narrow copy listens to the same bus; its bus answers are left open since timing is identical.
    mcsd_top #(.DATA_BITS(12), .CHANNELS(8)) mcsd_top_n_inst (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
        .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
        .s_axi_rready(s_axi_rready), .probe_chan_sel(n_chan_sel), .probe_chan_en(n_chan_en),
        .probe_ext_a_en(n_ext_a_en), .probe_ext_b_en(n_ext_b_en), .probe_output_oe(n_output_oe));

    // ==========================================================
    // Expectations and checks
    // Result is {driven, channel, external A, external B}.
    function automatic logic [3:0] exp_f(input logic [5:0] c, input logic en, input int ch);
        if (!en) return 4'h0;
        if (int'(c) < ch) return 4'hC;
        if (c == 6'h24) return 4'hA;
        if (c == 6'h25) return 4'h9;
        return 4'h0;
    endfunction

    function automatic logic [1:0] rt_f(input logic [3:0] e);
        return e[2] ? 2'b01 : (e[1] ? 2'b11 : (e[0] ? 2'b10 : 2'b00));
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_probe();
        logic [3:0] e1;
        logic [3:0] e2;
        e1 = exp_f(code_w, ctrl_m[9], 16);
        e2 = exp_f(code_n, ctrl_m[9], 8);
        chk({28'h0, probe_output_oe, probe_chan_en, probe_ext_a_en, probe_ext_b_en}, {28'h0, e1}, "wide route");
        chk({28'h0, n_output_oe, n_chan_en, n_ext_a_en, n_ext_b_en}, {28'h0, e2}, "narrow route");
        if (e1[2]) chk({28'h0, probe_chan_sel}, {28'h0, code_w[3:0]}, "wide channel");
        if (e2[2]) chk({28'h0, n_chan_sel}, {28'h0, code_n[3:0]}, "narrow channel");
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        mcsd_host_model_inst.rd(a, d, r);
        chk(d & msk, e, "read data");
        chk({30'h0, r}, {30'h0, er}, "read response");
    endtask

    task automatic cmd(input logic [19:0] w);
        logic [1:0] r;
        mcsd_host_model_inst.wr(OFS_CMD, {12'h000, w}, 4'hF, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY}, "command response");
        if (w[19:18] == 2'b00 && w[17:14] == 4'hA) begin
            code_w = w[13:8];
            code_n = w[11:6];
        end
        if (w[19:18] == 2'b00 && w[17:14] == 4'hC) ctrl_m = w[13:0];
        @(posedge core_clk);
        #1;
        chk_probe();
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        ctrl_m = 14'h2000;
        code_w = 6'h3F;
        code_n = 6'h3F;
        #1;
        chk_probe();
        rdchk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_2000, RESP_OKAY);
        rdchk(OFS_STAT, 32'h0000_0F3F, 32'h0000_003F, RESP_OKAY);
        rdchk(OFS_CMD, 32'hFFFF_FFFF, 32'h0000_0000, RESP_OKAY);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        stop_test();
    end

    // ==========================================================
    // Scenarios
    initial begin
        logic [1:0] r;
        num_errors = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        ce = 1'b1;
        void'($urandom(32'h759ddf67));
        do_reset();
        rdchk(8'h0C, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
        // Selecting while probing is off must not drive the pin; the host enables afterwards.
        cmd({6'h0A, 6'h05, 8'h5A});
        cmd({6'h0C, 14'h2200});
        rdchk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_2200, RESP_OKAY);
        for (int c = 0; c < 64; c++) begin
            pay = {c[5:0], 8'($urandom)};
            cmd({6'h0A, pay});
            rdchk(OFS_STAT, 32'h0000_0F3F, {20'h0, ctrl_m[9], exp_f(code_w, 1'b1, 16) >= 4'h8,
                  rt_f(exp_f(code_w, 1'b1, 16)), 2'h0, code_w}, RESP_OKAY);
        end
        cmd({6'h0A, 6'h03, 8'h00});
        mcsd_host_model_inst.wr(OFS_CTRL, 32'h0000_0000, 4'hF, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR}, "read-only write");
        // Without its strobe byte 2 would turn this word into a control write.
        mcsd_host_model_inst.wr(OFS_CMD, 32'hFFF3_2000, 4'h3, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY}, "strobed command response");
        rdchk(OFS_CMD, 32'hFFFF_FFFF, 32'h0000_2000, RESP_OKAY);
        rdchk(OFS_CTRL, 32'hFFFF_FFFF, {18'h0, ctrl_m}, RESP_OKAY);
        for (int s = 1; s < 4; s++) begin
            cmd({s[1:0], 4'hC, 14'h0000});
            cmd({s[1:0], 4'hA, 14'h3F00});
        end
        cmd({6'h08, 14'h3FFF});
        ce <= 1'b0;
        @(posedge core_clk);
        #1;
        chk({29'h0, s_axi_awready, s_axi_wready, s_axi_arready}, 32'h0, "ready while frozen");
        ce <= 1'b1;
        for (int i = 0; i < 200; i++) begin
            logic [19:0] w;
            w = 20'($urandom);
            if ($urandom % 3 != 0) w[19:18] = 2'b00;
            if ($urandom % 2 == 0) w[17:14] = ($urandom % 2 == 0) ? 4'hA : 4'hC;
            cmd(w);
            rdchk(OFS_CMD, 32'hFFFF_FFFF, {12'h000, w}, RESP_OKAY);
        end
        cmd({6'h0C, 14'h0000});
        do_reset();
        stop_test();
    end
endmodule // tb_top
